// file: rtl/ibwd_decoder.v
`timescale 1ns/1ns
`include "ibwd_regs.vh"

module ibwd_decoder (
  input wire clk,
  input wire reset_n,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // listener byte stream from the bus interface
  input wire listen_addressed,
  input wire rx_valid,
  input wire [7:0] rx_data,
  output wire rx_ready,
  // talker byte stream to the bus interface
  input wire talk_addressed,
  input wire serial_poll_mode,
  output wire tx_valid,
  output reg [7:0] tx_data,
  input wire tx_ready,
  output reg srq,
  // card cage side
  output reg card_gate,
  output reg [3:0] card_slot,
  output reg [11:0] card_data,
  output reg card_read_strobe,
  input wire card_flag,
  input wire card_irq,
  input wire [11:0] card_return
);

  // ****************************************
  // decoder states
  // ****************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_CTRL = 3'h1;
  localparam ST_SLOT = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_WAIT_FLAG = 3'h4;

  localparam RD_NONE = 2'h0;
  localparam RD_LATCHED = 2'h1;
  localparam RD_LIVE = 2'h2;

  reg [2:0] state;
  reg [11:0] acc;
  reg [3:0] slot;
  reg [3:0] own_unit;
  reg [3:0] unit;
  reg timed_mode_bit;
  reg system_enable_bit;
  reg transfer_enable_bit;
  reg input_path_select_bit;
  reg card_interrupt_arm_bit;
  reg [11:0] ret_data;
  reg ret_irq;
  reg [1:0] rd_mode;
  reg [2:0] tx_idx;
  reg ack;
  reg poll_q;
  reg word_q;
  reg [15:0] last_out;

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg flag_m;
  reg flag_s;
  reg flag_d;
  reg irq_m;
  reg irq_s;
  reg [11:0] ret_m;
  reg [11:0] ret_s;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flag_m <= 1'b0;
      flag_s <= 1'b0;
      flag_d <= 1'b0;
      irq_m <= 1'b0;
      irq_s <= 1'b0;
      ret_m <= 12'h000;
      ret_s <= 12'h000;
    end
    else
    begin
      flag_m <= card_flag;
      flag_s <= flag_m;
      flag_d <= flag_s;
      irq_m <= card_irq;
      irq_s <= irq_m;
      ret_m <= card_return;
      ret_s <= ret_m;
    end
  end

  // trailing edge of the card flag ends a gate/flag cycle
  wire flag_done = flag_d & ~flag_s;

  // ****************************************
  // character classification
  // ****************************************
  wire rx_take = rx_valid & rx_ready & listen_addressed; // see R2
  wire is_digit = (rx_data >= `IBWD_CH_ZERO) && (rx_data <= `IBWD_CH_SEVEN);
  wire is_slot = (rx_data >= `IBWD_CH_SLOT_FIRST) && (rx_data <= `IBWD_CH_SLOT_LAST);
  wire is_gate = rx_data == `IBWD_CH_GATE;
  wire is_nogate = rx_data == `IBWD_CH_NOGATE;
  wire is_live = rx_data == `IBWD_CH_LIVE;
  wire [2:0] digit = rx_data[2:0];
  wire selected = unit == own_unit; // see R9

  // no new characters while a gated read waits for its flag
  assign rx_ready = state != ST_WAIT_FLAG;

  // ****************************************
  // word decoder
  // ****************************************
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      acc <= 12'h000;
      slot <= 4'h0;
      unit <= 4'h0;
      timed_mode_bit <= 1'b0;
      system_enable_bit <= 1'b0;
      transfer_enable_bit <= 1'b0;
      input_path_select_bit <= 1'b0;
      card_interrupt_arm_bit <= 1'b0;
      card_gate <= 1'b0;
      card_slot <= 4'h0;
      card_data <= 12'h000;
      card_read_strobe <= 1'b0;
      ret_data <= 12'h000;
      ret_irq <= 1'b0;
      rd_mode <= RD_NONE;
      last_out <= 16'h0000;
    end
    else
    begin
      card_gate <= 1'b0;
      card_read_strobe <= 1'b0;
      if (rd_mode == RD_LIVE)
      begin
        ret_data <= ret_s; // see R19
        ret_irq <= irq_s;
      end
      case (state)
        ST_IDLE:
        begin
          if (rx_take) // see R3
          begin
            acc <= 12'h000;
            if (rx_data == `IBWD_CH_ZERO)
              state <= ST_CTRL; // see R4
            else if (is_slot)
            begin
              slot <= rx_data[3:0]; // see R11
              state <= ST_SLOT;
            end
          end
        end
        ST_CTRL:
        begin
          if (rx_take && is_digit)
            acc <= {acc[8:0], digit}; // see R6
          else if (rx_take && is_gate)
          begin
            // top digit acc[11:9] sets no mode or unit bit, but still goes out on card_data; see R5
            unit <= acc[`IBWD_UNIT_MSB:0]; // see R8
            timed_mode_bit <= acc[`IBWD_BIT_TIMED]; // see R7
            system_enable_bit <= acc[`IBWD_BIT_SYSTEM];
            transfer_enable_bit <= acc[`IBWD_BIT_TRANSFER];
            input_path_select_bit <= acc[`IBWD_BIT_INPATH];
            card_interrupt_arm_bit <= acc[`IBWD_BIT_ARM];
            card_gate <= 1'b1; // see R10
            card_slot <= 4'h0;
            card_data <= acc;
            state <= ST_IDLE;
          end
          else if (rx_take)
            state <= ST_IDLE;
        end
        ST_SLOT:
        begin
          if (rx_take && is_digit)
          begin
            acc <= {9'h000, digit};
            state <= ST_DATA;
          end
          else if (rx_take && is_gate && !input_path_select_bit)
          begin
            // slot then gate in an output mode is a zero data word
            if (selected) // see R14
            begin
              card_gate <= 1'b1; // see R12
              card_slot <= slot;
              card_data <= 12'h000;
              last_out <= {slot, 12'h000};
            end
            state <= ST_IDLE;
          end
          else if (rx_take && (is_gate || is_nogate || is_live))
          begin
            // address word, two characters only; see R16
            if (selected)
            begin
              card_slot <= slot;
              if (is_gate)
              begin
                card_gate <= 1'b1; // see R19
                rd_mode <= RD_NONE;
                state <= ST_WAIT_FLAG;
              end
              else if (is_nogate)
              begin
                card_read_strobe <= 1'b1;
                ret_data <= ret_s; // see R19
                ret_irq <= irq_s;
                rd_mode <= RD_LATCHED;
                state <= ST_IDLE;
              end
              else
              begin
                card_read_strobe <= 1'b1;
                rd_mode <= RD_LIVE;
                state <= ST_IDLE;
              end
            end
            else
              state <= ST_IDLE;
          end
          else if (rx_take)
            state <= ST_IDLE;
        end
        ST_DATA:
        begin
          if (rx_take && is_digit)
            acc <= {acc[8:0], digit}; // see R6
          else if (rx_take && is_gate)
          begin
            if (selected) // see R14
            begin
              card_gate <= 1'b1; // see R13
              card_slot <= slot;
              card_data <= acc;
              last_out <= {slot, acc};
            end
            state <= ST_IDLE;
          end
          else if (rx_take)
            state <= ST_IDLE;
        end
        ST_WAIT_FLAG:
        begin
          if (flag_done)
          begin
            ret_data <= ret_s; // see R19
            ret_irq <= 1'b1;
            rd_mode <= RD_LATCHED;
            state <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // service request
  // ****************************************
  wire poll_taken = tx_valid & tx_ready & serial_poll_mode; // see R1
  wire srq_set = timed_mode_bit & flag_done; // see R21

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      srq <= 1'b0;
    else if (srq_set)
      srq <= 1'b1; // set wins over the poll clear
    else if (poll_taken)
      srq <= 1'b0; // see R21
  end

  // ****************************************
  // talker
  // ****************************************
  wire have_word = rd_mode != RD_NONE;
  // valid lags a mode change or rd_mode leaving RD_NONE by one cycle, so tx_data is refreshed first
  assign tx_valid = talk_addressed & (serial_poll_mode ? poll_q : (~poll_q & word_q)); // see R17
  wire word_step = tx_valid & tx_ready & ~serial_poll_mode;
  wire next_srq = srq_set | (srq & ~poll_taken);

  function [7:0] word_byte;
    input [2:0] idx;
    input irq;
    input [11:0] val;
    begin
      case (idx)
        3'h0: word_byte = `IBWD_CH_ZERO | {7'h00, irq}; // see R20
        3'h1: word_byte = `IBWD_CH_ZERO | {5'h00, val[11:9]};
        3'h2: word_byte = `IBWD_CH_ZERO | {5'h00, val[8:6]};
        3'h3: word_byte = `IBWD_CH_ZERO | {5'h00, val[5:3]};
        3'h4: word_byte = `IBWD_CH_ZERO | {5'h00, val[2:0]};
        3'h5: word_byte = `IBWD_CH_CR;
        default: word_byte = `IBWD_CH_LF;
      endcase
    end
  endfunction

  // index 6 carries the line feed, so the word runs 0..6
  wire [2:0] last_idx = `IBWD_RET_WORD_LAST + 3'h1;
  wire [2:0] step_idx = !word_step ? tx_idx : (tx_idx == last_idx) ? 3'h0 : tx_idx + 3'h1;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_idx <= 3'h0;
      tx_data <= `IBWD_POLL_IDLE;
      poll_q <= 1'b0;
      word_q <= 1'b0;
    end
    else
    begin
      tx_idx <= step_idx;
      poll_q <= serial_poll_mode;
      word_q <= have_word;
      if (serial_poll_mode)
        tx_data <= next_srq ? `IBWD_POLL_SRQ : `IBWD_POLL_IDLE; // see R21
      else
        tx_data <= word_byte(step_idx, ret_irq, ret_data);
    end
  end

  // ****************************************
  // register bus, one wait cycle per access
  // ****************************************
  wire avs_req = avs_read | avs_write;
  assign avs_waitrequest = avs_req & ~ack;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack <= 1'b0;
      own_unit <= `IBWD_CONFIG_RESET;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack <= avs_req & ~ack;
      if (avs_write && ack && avs_address == `IBWD_OFS_CONFIG)
        own_unit <= avs_writedata[3:0];
      if (avs_read && !ack)
      begin
        case (avs_address)
          `IBWD_OFS_CONFIG: avs_readdata <= {28'h0, own_unit};
          `IBWD_OFS_STATUS: avs_readdata <= {16'h0, state, ret_irq, srq, rd_mode,
            card_interrupt_arm_bit, input_path_select_bit, transfer_enable_bit,
            system_enable_bit, timed_mode_bit, unit};
          `IBWD_OFS_LAST_OUT: avs_readdata <= {16'h0, last_out};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// file: pkg/ibwd_regs.vh
// Summary of operation
// R1: act only as talker, listener and serial-poll service requester; ignore other commands.
// R2: controller addresses the device as listener before sending any word.
// R3: process each received character in arrival order, acting on it at once.
// R4: a word starting with character zero is a control word.
// R5: the top octal digit of a control word is ignored. The code sets no bit from it but still sends it out on card_data.
// R6: octal digits are right-justified; omitted leading zeros read as zero.
// R7: mode digits decode to system, transfer, timed, input-path and interrupt-arm bits.
// R8: low control digits carry unit address 0 to 15, added to mode code.
// R9: only the mainframe matching the latest unit address answers data and address words.
// R10: control word ends with T, which starts the internal gate sequence.
// R11: data word slot character picks one of 15 slots, value 0000 to 7777.
// R12: slot character followed directly by T delivers zero to that slot. The code does so only while input_path_select_bit is clear.
// R13: data word ends with T, which strobes the value into the card.
// R14: data words go only to cards in the mainframe last selected.
// R15: controller selects an input mode and unit before any address word.
// R16: address word is slot character then T, X or Z read method.
// R17: return data word is sent only while addressed to talk.
// R18: in timed mode controller omits carriage return and line feed after writes.
// R19: T gates and latches on trailing flag edge; X latches now; Z is live.
// R20: return word is request character, four octal digits, carriage return, line feed.
// R21: service request only in timed mode on flag; poll byte 64 or 0 clears it.
`ifndef IBWD_REGS_VH
`define IBWD_REGS_VH

// ****************************************
// register map, byte addresses
// ****************************************
`define IBWD_OFS_CONFIG 4'h0
`define IBWD_OFS_STATUS 4'h4
`define IBWD_OFS_LAST_OUT 4'h8
`define IBWD_CONFIG_RESET 4'h0

// ****************************************
// characters on the bus
// ****************************************
`define IBWD_CH_ZERO 8'h30
`define IBWD_CH_SEVEN 8'h37
`define IBWD_CH_SLOT_FIRST 8'h40
`define IBWD_CH_SLOT_LAST 8'h4e
`define IBWD_CH_GATE 8'h54
`define IBWD_CH_NOGATE 8'h58
`define IBWD_CH_LIVE 8'h5a
`define IBWD_CH_CR 8'h0d
`define IBWD_CH_LF 8'h0a
`define IBWD_POLL_SRQ 8'h40
`define IBWD_POLL_IDLE 8'h00

// ****************************************
// control word field positions
// ****************************************
`define IBWD_UNIT_MSB 3
`define IBWD_BIT_TIMED 4
`define IBWD_BIT_SYSTEM 5
`define IBWD_BIT_TRANSFER 6
`define IBWD_BIT_INPATH 7
`define IBWD_BIT_ARM 8
`define IBWD_RET_WORD_LAST 3'h5

`endif

// file: verification/ibwd_decoder_properties.sv
`timescale 1ns/1ns
module ibwd_decoder_properties (
  input logic clk,
  input logic reset_n,
  input logic [3:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic avs_waitrequest,
  input logic listen_addressed,
  input logic rx_valid,
  input logic [7:0] rx_data,
  input logic rx_ready,
  input logic talk_addressed,
  input logic tx_valid,
  input logic serial_poll_mode,
  input logic [7:0] tx_data,
  input logic srq,
  input logic card_gate,
  input logic [3:0] card_slot,
  input logic [11:0] card_data,
  input logic card_read_strobe,
  input logic card_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire take = rx_valid && rx_ready && listen_addressed;
  // ****
  // bus, gate and talker checks
  // ****
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait cycle");
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
  a_wait_cause: assert property (avs_waitrequest |-> avs_read || avs_write)
    else $error("wait without request");
  a_gate_pulse: assert property (card_gate |=> !card_gate)
    else $error("gate too long");
  a_gate_cause: assert property (card_gate |-> $past(take && rx_data == 8'h54))
    else $error("gate without gate char");
  a_strobe_cause: assert property (card_read_strobe |->
    $past(take && (rx_data == 8'h58 || rx_data == 8'h5a)))
    else $error("strobe without read char");
  a_tx_talk: assert property (tx_valid |-> talk_addressed)
    else $error("talking while not addressed");
  a_slot_hold: assert property (!card_gate && !card_read_strobe |->
    $stable(card_slot) && $stable(card_data))
    else $error("slot or data moved without gate");
  a_poll_byte: assert property (tx_valid && serial_poll_mode |->
    tx_data == (srq ? 8'h40 : 8'h00))
    else $error("poll byte does not match service request");
  a_stall_end: assert property ($fell(card_flag) |-> ##[1:6] rx_ready)
    else $error("stall outlives flag");
endmodule
bind ibwd_decoder ibwd_decoder_properties i_ibwd_decoder_properties (.*);

// file: verification/ibwd_card_model.sv
`timescale 1ns/1ns
module ibwd_card_model (
  input logic clk,
  input logic card_gate,
  output logic card_flag,
  output logic card_irq,
  output logic [11:0] card_return
);
  // octal 1234 on the return lines
  parameter logic [11:0] RET = 12'h29c;
  initial
  begin
    card_flag = 1'b0;
    card_irq = 1'b0;
    card_return = RET;
  end
  // a busy card answers each gate with a flag pulse a few cycles late
  always @(posedge clk)
    if (card_gate === 1'b1)
    begin
      repeat (3) @(posedge clk);
      card_flag <= 1'b1;
      repeat (4) @(posedge clk);
      card_flag <= 1'b0;
    end
endmodule

// file: verification/ibwd_decoder_tb_top.sv
`timescale 1ns/1ns
module ibwd_decoder_tb_top;
  logic clk, reset_n, avs_read, avs_write, listen_addressed, rx_valid, rx_ready;
  logic [3:0] avs_address, card_slot;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic avs_waitrequest, talk_addressed, serial_poll_mode, tx_valid, tx_ready, srq;
  logic [7:0] rx_data, tx_data;
  logic card_gate, card_read_strobe, card_flag, card_irq;
  logic [11:0] card_data, card_return;
  logic [15:0] g_sd;
  int bad_count, n_tests, g_cnt, s_cnt;
  string m[8] = '{"0", "40", "140", "160", "240", "260", "460", "7177"};
  logic [8:0] e[8] = '{9'h000, 9'h020, 9'h060, 9'h070, 9'h0a0, 9'h0b0, 9'h130, 9'h07f};

  ibwd_decoder i_ibwd_decoder (.*);
  ibwd_card_model i_ibwd_card_model (.clk(clk), .card_gate(card_gate), .card_flag(card_flag),
    .card_irq(card_irq), .card_return(card_return));

  always @(posedge clk)
  begin
    if (card_gate === 1'b1)
    begin
      g_cnt <= g_cnt + 1;
      g_sd <= {card_slot, card_data};
    end
    if (card_read_strobe === 1'b1)
      s_cnt <= s_cnt + 1;
  end

  // ****
  // shared tasks
  // ****
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task send(input string s);
    for (int i = 0; i < s.len(); i++)
    begin
      rx_data <= s[i];
      rx_valid <= 1'b1;
      do
        @(posedge clk);
      while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    repeat (30) @(posedge clk);
  endtask
  task gate_chk(input string s, input int inc, input logic [15:0] sd);
    int c;
    c = g_cnt;
    send(s);
    chk(g_cnt - c, inc);
    if (inc > 0)
      chk(g_sd, sd);
  endtask
  task get_byte(input logic [7:0] exp);
    talk_addressed <= 1'b1;
    tx_ready <= 1'b1;
    do
      @(posedge clk);
    while (tx_valid !== 1'b1);
    chk(tx_data, exp);
  endtask
  task get_word(input string s);
    for (int i = 0; i < s.len(); i++)
      get_byte(s[i]);
    talk_addressed <= 1'b0;
    tx_ready <= 1'b0;
    serial_poll_mode <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // ****
  // scenarios
  // ****
  task t_modes;
    bus(1'b0, 4'h0, 0);
    chk(q, 0);
    bus(1'b0, 4'hc, 0);
    chk(q, 0);
    for (int i = 0; i < 8; i++)
    begin
      send({"0", m[i], "T"});
      bus(1'b0, 4'h4, 0);
      chk(q[8:0], e[i]);
    end
    $display("modes done");
  endtask
  task t_poll;
    send("0260T");
    chk(srq, 1'b1);
    serial_poll_mode <= 1'b1;
    get_word("@");
    chk(srq, 1'b0);
    serial_poll_mode <= 1'b1;
    get_byte(8'h00);
    get_word("");
    $display("poll done");
  endtask
  task t_data;
    send("040T");
    listen_addressed <= 1'b0;
    gate_chk("A1T", 0, 0);
    listen_addressed <= 1'b1;
    gate_chk("A7777T", 1, 16'h1fff);
    gate_chk("BT", 1, 16'h2000);
    gate_chk("C12345T", 1, 16'h34e5);
    send("041T");
    gate_chk("D5T", 0, 0);
    bus(1'b1, 4'h0, 1);
    bus(1'b0, 4'h0, 0);
    chk(q, 1);
    gate_chk("D5T", 1, 16'h4005);
    bus(1'b1, 4'h0, 0);
    $display("data done");
  endtask
  task t_read;
    int c;
    send("0240T");
    c = s_cnt;
    send("BX");
    chk(s_cnt - c, 1);
    get_word("01234\015\012");
    // a read gate leaves the data lines at the control word's field 0240
    gate_chk("BT", 1, 16'h20a0);
    get_word("11234\015\012");
    chk(srq, 1'b0);
    $display("read done");
  endtask

  task print_verdict;
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #100000;
    bad_count++;
    print_verdict;
  end
  initial
  begin
    {reset_n, avs_read, avs_write, rx_valid, tx_ready} = 0;
    {talk_addressed, serial_poll_mode, avs_address, avs_writedata, rx_data} = 0;
    {bad_count, n_tests, g_cnt, s_cnt} = 0;
    listen_addressed = 1'b1;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_modes;
    t_poll;
    t_data;
    t_read;
    print_verdict;
  end
endmodule
